// >>> usf_baud_gen.sv
// Oversampling enable generator from the integer and fractional divisor.
// Assumes the caller raises load_ok only between characters.
`timescale 1ns/1ps
module usf_baud_gen import usf_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] div_int,
	input  wire logic [5:0]  div_frac,
	input  wire logic        load_ok,
	output logic             tick16
);
	localparam logic [22:0] STEP = 23'(USF_FRAC_STEPS);

	logic [21:0] div_act_r;
	logic [22:0] acc_r;
	logic [22:0] acc_sum;

	// Divisor in use changes only between characters
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			div_act_r <= {USF_DIVI_RST, USF_DIVF_RST};
		else if (load_ok)
			div_act_r <= {div_int, div_frac};
	end

	assign acc_sum = acc_r + STEP;

	// Fractional accumulator in sixty-fourths, one tick per divisor
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r  <= 23'h0;
			tick16 <= 1'b0;
		end else if (load_ok && {div_int, div_frac} != div_act_r) begin
			acc_r  <= 23'h0; // Old residue would burst ticks
			tick16 <= 1'b0;
		end else if (div_act_r[21:6] == 16'h0000) begin
			acc_r  <= 23'h0; // Stopped while integer part is zero
			tick16 <= 1'b0;
		end else if (acc_sum >= {1'b0, div_act_r}) begin
			acc_r  <= acc_sum - {1'b0, div_act_r};
			tick16 <= 1'b1;
		end else begin
			acc_r  <= acc_sum;
			tick16 <= 1'b0;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	div_hold_a: assert property (!load_ok |=> $stable(div_act_r))
		else $error("divisor changed inside a character");
	tick_gap_a: assert property (
		(tick16 && div_act_r[21:7] != 15'h0) |=> !tick16)
		else $error("ticks too close for divisor of two or more");

endmodule // usf_baud_gen

// >>> usf_pkg.sv
// Package for the serial port status, flag and baud divisor block.
// Assumes a single 40 MHz system clock and byte addressed registers.
package usf_pkg;

	// Clock and oversampling figures
	localparam int USF_CLK_HZ     = 40000000;
	localparam int USF_OVERSAMPLE = 16;
	localparam int USF_FRAC_STEPS = 64;

	// Register byte offsets
	localparam logic [7:0] USF_A_DATA  = 8'h00;
	localparam logic [7:0] USF_A_RSTAT = 8'h04;
	localparam logic [7:0] USF_A_FLAGS = 8'h18;
	localparam logic [7:0] USF_A_INFRA = 8'h20;
	localparam logic [7:0] USF_A_BDI   = 8'h24;
	localparam logic [7:0] USF_A_BDF   = 8'h28;
	localparam logic [7:0] USF_A_LINE  = 8'h2c;
	localparam logic [7:0] USF_A_CTRL  = 8'h30;

	// Receive status bit positions
	localparam int USF_RS_OE = 3;
	localparam int USF_RS_BE = 2;
	localparam int USF_RS_PE = 1;
	localparam int USF_RS_FE = 0;

	// Line flag bit positions
	localparam int USF_FL_TX_EMPTY_FLAG = 7;
	localparam int USF_FL_RX_FULL_FLAG = 6;
	localparam int USF_FL_TX_FULL_FLAG = 5;
	localparam int USF_FL_RX_EMPTY_FLAG = 4;
	localparam int USF_FL_BUSY = 3;
	localparam int USF_FL_CTS  = 0;

	// Reset values
	localparam logic [15:0] USF_DIVI_RST = 16'h0000;
	localparam logic [5:0]  USF_DIVF_RST = 6'h00;
	localparam logic [7:0]  USF_LINE_RST = 8'h00;
	localparam logic        USF_CTRL_RST = 1'h0;

	// Line control layout, bit 7 down to bit 0
	typedef struct packed {
		logic       stick_parity_select;
		logic [1:0] wlen;
		logic       fifo_enable_bit;
		logic       stp2;
		logic       even_parity_select;
		logic       pen;
		logic       brk;
	} usf_line_t;

	// One received character with its error status
	typedef struct packed {
		logic       be;
		logic       pe;
		logic       fe;
		logic [7:0] data;
	} usf_char_t;

	// Parity bit sent or expected for a data byte
	function automatic logic usf_par_bit(input logic [7:0] d,
		input usf_line_t c);
		if (c.stick_parity_select)
			return ~c.even_parity_select;
		return c.even_parity_select ? ^d : ~^d;
	endfunction

	// Index of the last data bit, five to eight bits
	function automatic logic [2:0] usf_last_bit(input usf_line_t c);
		return 3'h4 + {1'b0, c.wlen};
	endfunction

endpackage

// >>> usf_remote.sv
// Remote serial device model on the far side of the serial line.
// Assumes one bit lasts BIT_CLKS system clocks (divisor 1, fraction 0).
`timescale 1ns/1ps
module usf_remote #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic       sys_clk,
	input  wire logic       tx_line,
	output logic            rx_line,
	output logic      [7:0] got,
	output int              n_got
);
	// Idle line is high (mark) between frames
	initial begin
		rx_line = 1'b1;
	end

	// Hold one bit level for a bit time, changed just after an edge
	task automatic put(input logic b);
		rx_line <= b;
		repeat (BIT_CLKS) @(posedge sys_clk);
	endtask

	// One frame: start, eight data bits, optional parity, stop, idle bit
	task automatic send(input logic [7:0] d, input logic pen, par, stp);
		@(posedge sys_clk);
		put(1'b0);
		for (int i = 0; i < 8; i++)
			put(d[i]);
		if (pen)
			put(par);
		put(stp);
		put(1'b1);
	endtask

	// Line low for nb bit times, then back to mark
	task automatic hold_low(input int nb);
		@(posedge sys_clk);
		rx_line <= 1'b0;
		repeat (nb * BIT_CLKS) @(posedge sys_clk);
		put(1'b1);
	endtask

	// Sample each transmitted frame in the middle of its eight data bits
	initial begin
		got = 8'h00;
		n_got = 0;
		forever begin
			@(negedge tx_line);
			repeat (BIT_CLKS / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge sys_clk);
				got[i] = tx_line;
			end
			n_got++;
		end
	end
endmodule // usf_remote

// >>> usf_rx_frame.sv
// Receive framer: samples the line at sixteen ticks per bit.
// Assumes rxd is already synchronised to sys_clk.
`timescale 1ns/1ps
module usf_rx_frame import usf_pkg::*; (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic tick16,
	input  wire logic rxd,
	input  usf_line_t cfg,
	output usf_char_t char_o,
	output logic      stb,
	output logic      idle
);
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD
	} usf_rx_st_t;

	usf_rx_st_t st_r;
	logic [3:0] cnt_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic       par_r;
	logic       zero_r;
	logic       brk;

	assign idle = (st_r == RX_IDLE) || (st_r == RX_HOLD);
	assign brk  = zero_r && !rxd;

	// Frame state machine
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r   <= RX_IDLE;
			cnt_r  <= 4'h0;
			bit_r  <= 3'h0;
			sh_r   <= 8'h00;
			par_r  <= 1'b0;
			zero_r <= 1'b0;
			stb    <= 1'b0;
			char_o <= '0;
		end else begin
			stb <= 1'b0;
			if (tick16) begin
				cnt_r <= cnt_r + 4'h1;
				case (st_r)
				RX_IDLE: begin
					cnt_r <= 4'h0;
					if (!rxd)
						st_r <= RX_START;
				end
				RX_START: if (cnt_r == 4'h7) begin
					cnt_r  <= 4'h0;
					bit_r  <= 3'h0;
					sh_r   <= 8'h00;
					zero_r <= 1'b1;
					st_r   <= rxd ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (cnt_r == 4'hf) begin
					sh_r[bit_r] <= rxd;
					zero_r      <= zero_r & ~rxd;
					bit_r       <= bit_r + 3'h1;
					if (bit_r == usf_last_bit(cfg))
						st_r <= cfg.pen ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (cnt_r == 4'hf) begin
					par_r  <= rxd;
					zero_r <= zero_r & ~rxd;
					st_r   <= RX_STOP;
				end
				RX_STOP: if (cnt_r == 4'hf) begin
					stb         <= 1'b1;
					char_o.be   <= brk;
					char_o.fe   <= !rxd;
					char_o.pe   <= cfg.pen && !brk &&
						(par_r != usf_par_bit(sh_r, cfg));
					char_o.data <= brk ? 8'h00 : sh_r;
					st_r        <= rxd ? RX_IDLE : RX_HOLD;
				end
				RX_HOLD: if (rxd)
					st_r <= RX_IDLE;
				default: st_r <= RX_IDLE;
				endcase
			end
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	brk_zero_a: assert property ((stb && char_o.be) |->
		(char_o.data == 8'h00 && st_r == RX_HOLD))
		else $error("break did not load a zero character");
	cv_break_c: cover property (stb && char_o.be);

endmodule // usf_rx_frame

// >>> usf_uart.sv
// Serial port with receive status, line flags and baud divisor.
// Assumes an Avalon-MM master on sys_clk and raw serial pins.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module usf_uart import usf_pkg::*; #(
	parameter int RX_DEPTH = 16,
	parameter int TX_DEPTH = 16
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_line,
	output logic             tx_line,
	input  wire logic        clear_to_send_input_n
);
	localparam int RW = $clog2(RX_DEPTH);
	localparam int TW = $clog2(TX_DEPTH);
	localparam logic [RW:0] RX_CAP = (RW + 1)'(RX_DEPTH);
	localparam logic [TW:0] TX_CAP = (TW + 1)'(TX_DEPTH);

	// Depths must be powers of two so the pointers wrap
	if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
		$error("RX_DEPTH must be a power of two of at least 2");
	if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0)
		$error("TX_DEPTH must be a power of two of at least 2");

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
	} usf_tx_st_t;

	logic        rxd_s1_r, rxd_s2_r, cts_s1_r, cts_s2_r;
	logic        ack_r, req, go, wr_go, rd_go;
	usf_line_t   line_r;
	logic        en_r;
	logic [15:0] divi_r;
	logic [5:0]  divf_r;
	logic [2:0]  rs_r;
	logic        oe_r;
	logic [31:0] rd_mux;
	logic [7:0]  flags;
	logic        tick16, rx_stb, rx_idle, busy;
	usf_char_t   rx_char, rx_head;

	usf_char_t   rx_mem_r [RX_DEPTH];
	logic [RW-1:0] rx_wp_r, rx_rp_r;
	logic [RW:0] rx_cnt_r;
	logic        rx_full, rx_empty, rx_push, rx_pop, rx_ovf;

	logic [7:0]  tx_mem_r [TX_DEPTH];
	logic [TW-1:0] tx_wp_r, tx_rp_r;
	logic [TW:0] tx_cnt_r;
	logic        tx_full, tx_empty, tx_push, tx_pop;

	usf_tx_st_t  tx_st_r;
	logic [3:0]  tx_c16_r;
	logic [2:0]  tx_bit_r;
	logic [7:0]  tx_sh_r;
	logic        tx_stop2_r, txd_r;

	// Two-stage synchronisers for the serial and modem pins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
			cts_s1_r <= 1'b1;
			cts_s2_r <= 1'b1;
		end else begin
			rxd_s1_r <= rx_line;
			rxd_s2_r <= rxd_s1_r;
			cts_s1_r <= clear_to_send_input_n;
			cts_s2_r <= cts_s1_r;
		end
	end

	// Bus slave: one wait cycle, access acts when waitrequest is low
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	assign go              = req & ack_r;
	assign wr_go           = go & avs_write;
	assign rd_go           = go & avs_read;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// Read data captured in the wait cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			avs_readdata <= 32'h0;
		else if (avs_read && !ack_r)
			avs_readdata <= rd_mux;
	end

	// Software registers; the infrared word has no storage at all
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_r <= usf_line_t'(USF_LINE_RST);
			en_r   <= USF_CTRL_RST;
			divi_r <= USF_DIVI_RST;
			divf_r <= USF_DIVF_RST;
		end else if (wr_go) begin
			case (avs_address)
			USF_A_LINE: if (avs_byteenable[0])
				line_r <= usf_line_t'(avs_writedata[7:0]);
			USF_A_CTRL: if (avs_byteenable[0])
				en_r <= avs_writedata[0];
			USF_A_BDI: begin
				if (avs_byteenable[0])
					divi_r[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					divi_r[15:8] <= avs_writedata[15:8];
			end
			USF_A_BDF: if (avs_byteenable[0])
				divf_r <= avs_writedata[5:0];
			default: ;
			endcase
		end
	end

	// Oversampling enable; divisor reloads only between characters
	usf_baud_gen u_baud (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.div_int  (divi_r),
		.div_frac (divf_r),
		.load_ok  (rx_idle && tx_st_r == TX_IDLE),
		.tick16   (tick16)
	);

	usf_rx_frame u_rx (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick16  (tick16),
		.rxd     (rxd_s2_r),
		.cfg     (line_r),
		.char_o  (rx_char),
		.stb     (rx_stb),
		.idle    (rx_idle)
	);

	// Receive queue: one entry deep unless FIFO mode is on
	assign rx_full  = rx_cnt_r >= (line_r.fifo_enable_bit ? RX_CAP : (RW + 1)'(1));
	assign rx_empty = rx_cnt_r == '0;
	assign rx_push  = rx_stb & en_r & ~rx_full;
	assign rx_ovf   = rx_stb & en_r & rx_full;
	assign rx_pop   = rd_go & (avs_address == USF_A_DATA) & ~rx_empty;
	assign rx_head  = rx_mem_r[rx_rp_r];

	always_ff @(posedge sys_clk) begin
		if (rx_push)
			rx_mem_r[rx_wp_r] <= rx_char;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_r  <= '0;
			rx_rp_r  <= '0;
			rx_cnt_r <= '0;
		end else begin
			if (rx_push)
				rx_wp_r <= rx_wp_r + RW'(1);
			if (rx_pop)
				rx_rp_r <= rx_rp_r + RW'(1);
			rx_cnt_r <= rx_cnt_r + (RW + 1)'(rx_push)
				- (RW + 1)'(rx_pop);
		end
	end

	// Status of the character last taken from the data register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rs_r <= 3'h0;
		else if (rx_pop)
			rs_r <= {rx_head.be, rx_head.pe, rx_head.fe};
		else if (wr_go && avs_address == USF_A_RSTAT)
			rs_r <= 3'h0;
	end

	// Overrun flag: set wins over any clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			oe_r <= 1'b0;
		else if (rx_ovf)
			oe_r <= 1'b1;
		else if (!rx_full)
			oe_r <= 1'b0;
		else if (wr_go && avs_address == USF_A_RSTAT)
			oe_r <= 1'b0;
	end

	// Transmit queue, fed by data register writes
	assign tx_full  = tx_cnt_r >= (line_r.fifo_enable_bit ? TX_CAP : (TW + 1)'(1));
	assign tx_empty = tx_cnt_r == '0;
	assign tx_push  = wr_go & (avs_address == USF_A_DATA)
		& avs_byteenable[0] & ~tx_full;
	assign tx_pop   = (tx_st_r == TX_IDLE) & en_r & ~tx_empty;

	always_ff @(posedge sys_clk) begin
		if (tx_push)
			tx_mem_r[tx_wp_r] <= avs_writedata[7:0];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_r  <= '0;
			tx_rp_r  <= '0;
			tx_cnt_r <= '0;
		end else begin
			if (tx_push)
				tx_wp_r <= tx_wp_r + TW'(1);
			if (tx_pop)
				tx_rp_r <= tx_rp_r + TW'(1);
			tx_cnt_r <= tx_cnt_r + (TW + 1)'(tx_push)
				- (TW + 1)'(tx_pop);
		end
	end

	// Transmit shifter: start, data, optional parity, one or two stops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r    <= TX_IDLE;
			tx_c16_r   <= 4'h0;
			tx_bit_r   <= 3'h0;
			tx_sh_r    <= 8'h00;
			tx_stop2_r <= 1'b0;
			txd_r      <= 1'b1;
		end else begin
			case (tx_st_r)
			TX_IDLE: begin
				txd_r    <= ~line_r.brk; // Held low while break is set
				tx_c16_r <= 4'h0;
				if (tx_pop) begin
					tx_sh_r <= tx_mem_r[tx_rp_r];
					txd_r   <= 1'b0;
					tx_st_r <= TX_START;
				end
			end
			default: if (tick16) begin
				tx_c16_r <= tx_c16_r + 4'h1;
				if (tx_c16_r == 4'hf) begin
					case (tx_st_r)
					TX_START: begin
						tx_bit_r <= 3'h0;
						txd_r    <= tx_sh_r[0];
						tx_st_r  <= TX_DATA;
					end
					TX_DATA: if (tx_bit_r == usf_last_bit(line_r)) begin
						txd_r <= line_r.pen ?
							usf_par_bit(tx_sh_r, line_r) : 1'b1;
						tx_stop2_r <= line_r.stp2;
						tx_st_r    <= line_r.pen ? TX_PAR : TX_STOP;
					end else begin
						tx_bit_r <= tx_bit_r + 3'h1;
						txd_r    <= tx_sh_r[tx_bit_r + 3'h1];
					end
					TX_PAR: begin
						txd_r   <= 1'b1;
						tx_st_r <= TX_STOP;
					end
					TX_STOP: if (tx_stop2_r)
						tx_stop2_r <= 1'b0;
					else
						tx_st_r <= TX_IDLE;
					default: tx_st_r <= TX_IDLE;
					endcase
				end
			end
			endcase
		end
	end

	assign tx_line = txd_r;
	assign busy    = ~tx_empty | (tx_st_r != TX_IDLE);

	// Line flags; unused modem bits read as zero
	always_comb begin
		flags              = 8'h00;
		flags[USF_FL_TX_EMPTY_FLAG] = tx_empty;
		flags[USF_FL_RX_FULL_FLAG] = rx_full;
		flags[USF_FL_TX_FULL_FLAG] = tx_full;
		flags[USF_FL_RX_EMPTY_FLAG] = rx_empty;
		flags[USF_FL_BUSY] = busy;
		flags[USF_FL_CTS]  = ~cts_s2_r;
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0;
		case (avs_address)
		USF_A_DATA: if (!rx_empty)
			rd_mux = {20'h0, oe_r, rx_head};
		USF_A_RSTAT: rd_mux = {28'h0, oe_r, rs_r};
		USF_A_FLAGS: rd_mux = {24'h0, flags};
		USF_A_INFRA: rd_mux = 32'h0;
		USF_A_BDI:   rd_mux = {16'h0, divi_r};
		USF_A_BDF:   rd_mux = {26'h0, divf_r};
		USF_A_LINE:  rd_mux = {24'h0, line_r};
		USF_A_CTRL:  rd_mux = {31'h0, en_r};
		default:     rd_mux = 32'h0;
		endcase
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	oe_set_a: assert property (rx_ovf |=> oe_r)
		else $error("overrun not flagged at once");
	oe_clear_a: assert property ((oe_r && !rx_full) |=> !oe_r)
		else $error("overrun kept with room in queue");
	rs_load_a: assert property (rx_pop |=>
		rs_r == {$past(rx_head.be), $past(rx_head.pe), $past(rx_head.fe)})
		else $error("status does not match read character");
	rs_wclr_a: assert property ((wr_go && avs_address == USF_A_RSTAT
		&& !rx_ovf) |=> (rs_r == 3'h0 && !oe_r))
		else $error("status write did not clear errors");
	tx_empty_flag_a: assert property ((tx_push && tx_empty) |=>
		(!flags[USF_FL_TX_EMPTY_FLAG] && busy))
		else $error("transmit empty flag wrong after push");
	busy_hold_a: assert property ((tx_st_r == TX_STOP && !tick16)
		|=> busy)
		else $error("busy dropped before stop bit ended");
	busy_data_a: assert property (!tx_empty |-> busy)
		else $error("busy low with data queued");
	cts_flag_a: assert property (
		(!clear_to_send_input_n)[*3] |-> flags[USF_FL_CTS])
		else $error("clear to send flag not set");
	infra_zero_a: assert property ((rd_go &&
		avs_address == USF_A_INFRA) |-> avs_readdata == 32'h0)
		else $error("infrared register read nonzero");
	char_mode_a: assert property ((!line_r.fifo_enable_bit && rx_cnt_r != '0)
		|-> (flags[USF_FL_RX_FULL_FLAG] && !flags[USF_FL_RX_EMPTY_FLAG]))
		else $error("holding register flags wrong");
	wait_one_a: assert property ((req && !ack_r) |=> !avs_waitrequest)
		else $error("bus answer late");

	cv_overrun_c: cover property (rx_ovf);
	cv_parity_c: cover property (rx_push && rx_char.pe);
	cv_tx_done_c: cover property (tx_st_r == TX_STOP ##1 tx_st_r == TX_IDLE);
	cv_status_rd_c: cover property (rx_pop ##[1:20] rd_go &&
		avs_address == USF_A_RSTAT);

endmodule // usf_uart

// >>> usf_uart_tb_top.sv
// Testbench for the serial port status, flag and divisor block.
// Assumes the remote model and a one wait state Avalon-MM slave.
`timescale 1ns/1ps
module usf_uart_tb_top import usf_pkg::*;;
	logic        sys_clk;
	logic        rst_n;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx_line;
	logic        tx_line;
	logic        cts_n;
	logic [7:0]  got;
	int          n_got;
	int          mismatches;
	int          n_tests;
	int          cycles;
	usf_line_t   c;
	logic [7:0]  d;

	usf_uart #(.RX_DEPTH(4), .TX_DEPTH(4)) i_dut (
		.sys_clk              (sys_clk),
		.rst_n                (rst_n),
		.avs_address          (avs_address),
		.avs_read             (avs_read),
		.avs_write            (avs_write),
		.avs_writedata        (avs_writedata),
		.avs_byteenable       (avs_byteenable),
		.avs_readdata         (avs_readdata),
		.avs_waitrequest      (avs_waitrequest),
		.rx_line              (rx_line),
		.tx_line              (tx_line),
		.clear_to_send_input_n(cts_n)
	);

	usf_remote #(.BIT_CLKS(16)) i_rem (
		.sys_clk(sys_clk),
		.tx_line(tx_line),
		.rx_line(rx_line),
		.got    (got),
		.n_got  (n_got)
	);

	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
	end
	always #12.5 sys_clk = ~sys_clk;

	// Print counts and verdict, then stop
	task automatic conclude();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compare a seen value against the expected one
	task automatic chk(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h",
				$time, seen, exp);
		end
	endtask

	// One bus cycle, held until waitrequest is seen low
	task automatic req(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= wd;
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] q;
		req(a, 1'b1, wd, q);
	endtask

	// Read and compare under a mask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] q;
		req(a, 1'b0, 32'h0, q);
		chk(q & m, e);
	endtask

	// Parity bit the receiver expects
	function automatic logic epar(input logic [7:0] v, input logic e, s);
		return s ? ~e : (e ? ^v : ~^v);
	endfunction

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		cts_n = 1'b1;
		mismatches = 0;
		n_tests = 0;
		cycles = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(USF_A_FLAGS, 32'hf9, 32'h90);
		rdc(USF_A_BDI, 32'hffffffff, 32'h0);
		rdc(USF_A_BDF, 32'hffffffff, 32'h0);
		cts_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rdc(USF_A_FLAGS, 32'h1, 32'h1);
		wr(USF_A_BDI, 32'habcd1234);
		rdc(USF_A_BDI, 32'hffffffff, 32'h1234);
		wr(USF_A_BDF, 32'hff);
		rdc(USF_A_BDF, 32'hffffffff, 32'h3f);
		wr(USF_A_INFRA, 32'hffffffff);
		rdc(USF_A_INFRA, 32'hffffffff, 32'h0);
		rdc(8'h3c, 32'hffffffff, 32'h0);
		wr(USF_A_BDI, 32'h1);
		wr(USF_A_BDF, 32'h0);
		wr(USF_A_CTRL, 32'h1);
		// Every parity mode with a correct parity bit
		for (int k = 0; k < 4; k++) begin
			c = usf_line_t'(8'h72);
			c.stick_parity_select = k[1];
			c.even_parity_select = k[0];
			wr(USF_A_LINE, {24'h0, c});
			d = 8'h35 + 8'(k);
			i_rem.send(d, 1'b1, epar(d, c.even_parity_select, c.stick_parity_select), 1'b1);
			rdc(USF_A_DATA, 32'hfff, {24'h0, d});
		end
		i_rem.send(8'h3c, 1'b1, ~epar(8'h3c, 1'b1, 1'b1), 1'b1);
		rdc(USF_A_DATA, 32'hf00, 32'h200);
		rdc(USF_A_RSTAT, 32'hf, 32'h2);
		wr(USF_A_RSTAT, 32'h0);
		rdc(USF_A_RSTAT, 32'hf, 32'h0);
		i_rem.send(8'h81, 1'b1, epar(8'h81, 1'b1, 1'b1), 1'b0);
		rdc(USF_A_DATA, 32'hfff, 32'h181);
		rdc(USF_A_RSTAT, 32'hf, 32'h1);
		i_rem.hold_low(14);
		rdc(USF_A_DATA, 32'h7ff, 32'h500);
		rdc(USF_A_RSTAT, 32'h7, 32'h5);
		rdc(USF_A_FLAGS, 32'h10, 32'h10);
		i_rem.send(8'h42, 1'b1, epar(8'h42, 1'b1, 1'b1), 1'b1);
		rdc(USF_A_DATA, 32'hfff, 32'h42);
		rdc(USF_A_RSTAT, 32'h7, 32'h0);
		// Fill the four entry queue, then one more
		for (int i = 1; i <= 5; i++) begin
			d = 8'h11 * 8'(i);
			i_rem.send(d, 1'b1, epar(d, 1'b1, 1'b1), 1'b1);
			if (i == 4)
				rdc(USF_A_FLAGS, 32'h50, 32'h40);
		end
		rdc(USF_A_RSTAT, 32'h8, 32'h8);
		for (int i = 1; i <= 4; i++) begin
			rdc(USF_A_DATA, 32'h7ff, 32'h11 * i);
			if (i == 1)
				rdc(USF_A_RSTAT, 32'h8, 32'h0);
		end
		rdc(USF_A_FLAGS, 32'h50, 32'h10);
		// Holding register mode
		c.fifo_enable_bit = 1'b0;
		wr(USF_A_LINE, {24'h0, c});
		i_rem.send(8'h66, 1'b1, epar(8'h66, 1'b1, 1'b1), 1'b1);
		rdc(USF_A_FLAGS, 32'h50, 32'h40);
		rdc(USF_A_DATA, 32'hfff, 32'h66);
		// Transmit while held off, then released
		wr(USF_A_CTRL, 32'h0);
		c.pen = 1'b0;
		wr(USF_A_LINE, {24'h0, c});
		wr(USF_A_DATA, 32'ha6);
		rdc(USF_A_FLAGS, 32'ha8, 32'h28);
		wr(USF_A_CTRL, 32'h1);
		while (n_got == 0)
			@(posedge sys_clk);
		chk({24'h0, got}, 32'ha6);
		rdc(USF_A_FLAGS, 32'h88, 32'h88);
		repeat (40) @(posedge sys_clk);
		rdc(USF_A_FLAGS, 32'h88, 32'h80);
		conclude();
	end
endmodule // usf_uart_tb_top
